// file: rtl/compare_channel.sv
// One compare channel: value register, match detect and output pin
`include "timer_consts.svh"
module compare_channel
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic init,
   // Register write
   input wire logic wr_en,
   input wire timer_pkg::count_type wr_data,
   // Counter view
   input wire timer_pkg::count_type running_counter,
   input wire logic tick,
   input wire logic out_level,
   // Results
   output timer_pkg::count_type value,
   output logic match,
   output logic pin
);
   count_type value_r;
   logic pin_r;
   wire logic equal = (running_counter == value_r);

   // Match fires in the last state of equality, at the count update
   assign match = tick & equal;
   assign value = value_r;
   assign pin = pin_r;

   always_ff @(posedge ref_clk) begin
      if (init) begin
         value_r <= `RST_CMP;
      end else if (wr_en) begin
         value_r <= wr_data;
      end
   end

   // pin takes level at each match, zero at init
   always_ff @(posedge ref_clk) begin
      if (init) begin
         pin_r <= 1'b0;
      end else if (match) begin
         pin_r <= out_level;
      end
   end

   // pin stays low until the first match
   chk_pin_low_idle: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(pin_r) |-> $past(match) && $past(out_level))
      else $error("compare pin rose without a match");
   chk_pin_level: assert property (@(posedge ref_clk) disable iff (rst)
      match && !init |=> pin_r == $past(out_level))
      else $error("compare pin level wrong after match");
endmodule

// file: rtl/timer_compare_capture_irq.sv
// Timer compare, capture, interrupt enable and status logic on an 8-bit bus
`include "timer_consts.svh"
module timer_compare_capture_irq
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Power modes
   input wire logic standby,
   input wire logic module_standby,
   // Byte register bus
   input wire logic [7:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire timer_pkg::byte_type bus_wdata,
   output timer_pkg::byte_type bus_rdata,
   // Pins
   input wire logic count_clk_in,
   input wire logic capture_in,
   output logic compare_out_a,
   output logic compare_out_b,
   // Interrupt requests
   output logic capture_irq,
   output logic match_a_irq,
   output logic match_b_irq,
   output logic wrap_irq
);
   import timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   count_type running_counter_r, running_counter_nxt;
   count_type capture_value_r;
   byte_type temp_r;
   byte_type irq_enable_r;
   byte_type timer_ctrl_r;
   byte_type out_ctrl_r;
   byte_type rdata_r, rdata_nxt;
   logic capture_flag_r, match_a_flag_r, match_b_flag_r, wrap_flag_r;
   logic capture_flag_nxt, match_a_flag_nxt, match_b_flag_nxt, wrap_flag_nxt;
   logic clear_on_match_a_r;
   logic [3:0] armed_r; // Flags seen as one by a status read
   logic [6:0] pre_r;
   logic ext_prev_r, cap_prev_r, cap_pend_r;
   logic [3:0] irq_r;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic init = rst | standby | module_standby;
   wire logic rd_cs = bus_rd & (bus_addr == `OFS_CTRL_STATUS);
   wire logic wr_cs = bus_wr & (bus_addr == `OFS_CTRL_STATUS);
   wire logic wr_ie = bus_wr & (bus_addr == `OFS_IRQ_EN);
   wire logic wr_tc = bus_wr & (bus_addr == `OFS_TIMER_CTRL);
   wire logic wr_oc = bus_wr & (bus_addr == `OFS_OUT_CTRL);
   wire logic wr_cnt_hi = bus_wr & (bus_addr == `OFS_COUNT_HI);
   wire logic wr_cnt_lo = bus_wr & (bus_addr == `OFS_COUNT_LO);
   wire logic wr_cmp_hi = bus_wr & (bus_addr == `OFS_CMP_HI);
   wire logic wr_cmp_lo = bus_wr & (bus_addr == `OFS_CMP_LO);
   wire logic rd_cnt_hi = bus_rd & (bus_addr == `OFS_COUNT_HI);
   wire logic rd_cap_hi = bus_rd & (bus_addr == `OFS_CAP_HI);
   wire logic compare_reg_sel = out_ctrl_r[`OC_SEL];
   // select routes the shared address only
   wire logic wr_cmp_a = wr_cmp_lo & ~compare_reg_sel;
   wire logic wr_cmp_b = wr_cmp_lo & compare_reg_sel;
   // lower write commits temporary upper byte
   wire count_type wr_word = {temp_r, bus_wdata};

   ////////////////////////////////////////////////////////////////////////
   // Count tick: internal prescaler or sampled external rising edge
   wire clk_src_type clk_src = clk_src_type'(timer_ctrl_r[`TC_CKS_HI:`TC_CKS_LO]);
   logic [6:0] pre_mask;
   always_comb begin
      case (clk_src)
         SRC_DIV8: pre_mask = `PRE_MASK_8;
         SRC_DIV32: pre_mask = `PRE_MASK_32;
         SRC_DIV128: pre_mask = `PRE_MASK_128;
         default: pre_mask = `PRE_MASK_8;
      endcase
   end
   wire logic ext_tick = count_clk_in & ~ext_prev_r;
   wire logic tick = (clk_src == SRC_EXT) ? ext_tick : ((pre_r & pre_mask) == pre_mask);

   ////////////////////////////////////////////////////////////////////////
   // Compare channels
   count_type compare_value_a, compare_value_b;
   logic match_a, match_b;
   logic pin_a, pin_b;

   compare_channel chan_a (
      .ref_clk(ref_clk),
      .rst(rst),
      .init(init),
      .wr_en(wr_cmp_a),
      .wr_data(wr_word),
      .running_counter(running_counter_r),
      .tick(tick),
      .out_level(out_ctrl_r[`OC_LEVEL_A]),
      .value(compare_value_a),
      .match(match_a),
      .pin(pin_a)
   );

   compare_channel chan_b (
      .ref_clk(ref_clk),
      .rst(rst),
      .init(init),
      .wr_en(wr_cmp_b),
      .wr_data(wr_word),
      .running_counter(running_counter_r),
      .tick(tick),
      .out_level(out_ctrl_r[`OC_LEVEL_B]),
      .value(compare_value_b),
      .match(match_b),
      .pin(pin_b)
   );

   assign compare_out_a = pin_a;
   assign compare_out_b = pin_b;

   ////////////////////////////////////////////////////////////////////////
   // Counter next value; a match A clear takes the place of the increment
   wire logic clear_hit = match_a & clear_on_match_a_r;
   wire logic wrap_hit = tick & ~clear_hit & (running_counter_r == `COUNT_MAX);
   always_comb begin
      if (wr_cnt_lo) begin
         running_counter_nxt = wr_word;
      end else if (clear_hit) begin
         running_counter_nxt = `RST_COUNT;
      end else if (tick) begin
         running_counter_nxt = running_counter_r + 16'h0001;
      end else begin
         running_counter_nxt = running_counter_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture edge; an edge during an upper capture read waits one cycle,
   // so the pair of bytes read always belongs to one capture
   wire logic cap_rise = capture_in & ~cap_prev_r;
   wire logic cap_fall = ~capture_in & cap_prev_r;
   wire logic cap_edge = timer_ctrl_r[`TC_EDGE] ? cap_rise : cap_fall;
   wire logic cap_go = (cap_edge | cap_pend_r) & ~rd_cap_hi;

   ////////////////////////////////////////////////////////////////////////
   // Flag clear: read while one, then write zero; a one written is ignored
   // armed clear by zero write
   wire logic [3:0] clr = {4{wr_cs}} & armed_r &
      ~{bus_wdata[`CS_CAPTURE], bus_wdata[`CS_MATCH_A],
        bus_wdata[`CS_MATCH_B], bus_wdata[`CS_WRAP]};
   // set wins over a coinciding clear
   assign capture_flag_nxt = cap_go | (capture_flag_r & ~clr[3]);
   assign match_a_flag_nxt = match_a | (match_a_flag_r & ~clr[2]);
   assign match_b_flag_nxt = match_b | (match_b_flag_r & ~clr[1]);
   assign wrap_flag_nxt = wrap_hit | (wrap_flag_r & ~clr[0]);
   wire logic [3:0] flags = {capture_flag_r, match_a_flag_r, match_b_flag_r, wrap_flag_r};

   ////////////////////////////////////////////////////////////////////////
   // Read data: reserved bits fixed, counter and capture through temporary
   // enable bits 6..4 zero, bit 0 one
   wire byte_type ie_view = (irq_enable_r & 8'h8e) | `IE_ONE_MASK;
   wire byte_type cs_view = {capture_flag_r, 3'b000, match_a_flag_r, match_b_flag_r,
      wrap_flag_r, clear_on_match_a_r};
   wire count_type cmp_view = compare_reg_sel ? compare_value_b : compare_value_a;
   always_comb begin
      case (bus_addr)
         `OFS_IRQ_EN: rdata_nxt = ie_view;
         `OFS_CTRL_STATUS: rdata_nxt = cs_view;
         `OFS_COUNT_HI: rdata_nxt = running_counter_r[15:8];
         `OFS_COUNT_LO: rdata_nxt = temp_r;
         `OFS_CMP_HI: rdata_nxt = cmp_view[15:8];
         `OFS_CMP_LO: rdata_nxt = cmp_view[7:0];
         `OFS_TIMER_CTRL: rdata_nxt = timer_ctrl_r & 8'h83;
         `OFS_OUT_CTRL: rdata_nxt = (out_ctrl_r & 8'h13) | `OC_ONE_MASK;
         `OFS_CAP_HI: rdata_nxt = capture_value_r[15:8];
         `OFS_CAP_LO: rdata_nxt = temp_r;
         default: rdata_nxt = `RST_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter, prescaler and pin history
   always_ff @(posedge ref_clk) begin
      if (init) begin
         running_counter_r <= `RST_COUNT;
         pre_r <= 7'h00;
         ext_prev_r <= 1'b0;
         cap_prev_r <= 1'b0;
         cap_pend_r <= 1'b0;
      end else begin
         running_counter_r <= running_counter_nxt;
         pre_r <= pre_r + 7'h01;
         ext_prev_r <= count_clk_in;
         cap_prev_r <= capture_in;
         cap_pend_r <= cap_edge & rd_cap_hi;
      end
   end

   // temporary byte: upper write parks, upper read stashes low half
   always_ff @(posedge ref_clk) begin
      if (init) begin
         temp_r <= `RST_BYTE;
      end else if (wr_cnt_hi | wr_cmp_hi) begin
         temp_r <= bus_wdata;
      end else if (rd_cnt_hi) begin
         temp_r <= running_counter_r[7:0];
      end else if (rd_cap_hi) begin
         temp_r <= capture_value_r[7:0];
      end
   end

   // capture value read-only, zero at init
   always_ff @(posedge ref_clk) begin
      if (init) begin
         capture_value_r <= `RST_CAP;
      end else if (cap_go) begin
         capture_value_r <= running_counter_r;
      end
   end

   // Control registers and flags
   always_ff @(posedge ref_clk) begin
      if (init) begin
         irq_enable_r <= `IE_ONE_MASK;
         timer_ctrl_r <= `RST_BYTE;
         out_ctrl_r <= `RST_OUT_CTRL;
         clear_on_match_a_r <= 1'b0;
         {capture_flag_r, match_a_flag_r, match_b_flag_r, wrap_flag_r} <= 4'h0;
         armed_r <= 4'h0;
      end else begin
         if (wr_ie) irq_enable_r <= bus_wdata;
         if (wr_tc) timer_ctrl_r <= bus_wdata;
         if (wr_oc) out_ctrl_r <= bus_wdata;
         if (wr_cs) clear_on_match_a_r <= bus_wdata[`CS_CLEAR_A];
         capture_flag_r <= capture_flag_nxt;
         match_a_flag_r <= match_a_flag_nxt;
         match_b_flag_r <= match_b_flag_nxt;
         wrap_flag_r <= wrap_flag_nxt;
         // A status write consumes the arming whatever it wrote
         armed_r <= wr_cs ? 4'h0 : (armed_r | ({4{rd_cs}} & flags));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt requests, registered: one cycle behind the flags
   // enable gating
   wire logic [3:0] irq_nxt = flags & {irq_enable_r[`IE_CAPTURE], irq_enable_r[`IE_MATCH_A],
      irq_enable_r[`IE_MATCH_B], irq_enable_r[`IE_WRAP]};
   always_ff @(posedge ref_clk) begin
      if (init) begin
         irq_r <= 4'h0;
         rdata_r <= `RST_BYTE;
      end else begin
         irq_r <= irq_nxt;
         rdata_r <= bus_rd ? rdata_nxt : `RST_BYTE;
      end
   end
   assign {capture_irq, match_a_irq, match_b_irq, wrap_irq} = irq_r;
   assign bus_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (init);

   chk_match_flag_set: assert property (
      match_a |=> match_a_flag_r)
      else $error("match A did not set its flag");
   chk_capture_copy: assert property (
      cap_go |=> capture_flag_r && capture_value_r == $past(running_counter_r))
      else $error("capture did not copy counter and set flag");
   chk_capture_edge: assert property (
      $past(capture_in) && !capture_in && !timer_ctrl_r[`TC_EDGE] && !rd_cap_hi
      |-> cap_go)
      else $error("falling capture edge missed");
   chk_irq_gate: assert property (
      !capture_flag_r || !irq_enable_r[`IE_CAPTURE] |=> !capture_irq)
      else $error("capture request without flag and enable");
   chk_irq_match_a: assert property (
      match_a_flag_r && irq_enable_r[`IE_MATCH_A] |=> match_a_irq)
      else $error("match A request missing");
   chk_irq_match_b: assert property (
      match_b_flag_r && irq_enable_r[`IE_MATCH_B] |=> match_b_irq)
      else $error("match B request missing");
   chk_irq_wrap: assert property (
      wrap_flag_r && irq_enable_r[`IE_WRAP] |=> wrap_irq)
      else $error("wrap request missing");
   chk_wrap_flag: assert property (
      wrap_hit && !wr_cnt_lo |=> wrap_flag_r && running_counter_r == `RST_COUNT)
      else $error("wrap did not set flag");
   chk_clear_on_a: assert property (
      clear_hit && !wr_cnt_lo |=> running_counter_r == `RST_COUNT)
      else $error("counter not cleared on match A");
   chk_set_wins: assert property (
      match_b && clr[1] |=> match_b_flag_r)
      else $error("flag lost when set met clear");
   chk_no_sw_set: assert property (
      !match_a_flag_r && !match_a |=> !match_a_flag_r)
      else $error("flag set without hardware event");
   chk_ie_read: assert property (
      bus_rd && bus_addr == `OFS_IRQ_EN |=> bus_rdata[0] && bus_rdata[6:4] == 3'b000)
      else $error("enable reserved bits wrong");
   chk_cs_read: assert property (
      bus_rd && bus_addr == `OFS_CTRL_STATUS |=> bus_rdata[6:4] == 3'b000)
      else $error("status reserved bits wrong");

   // Flag lands one edge after the capture, the request one edge later
   cov_capture: cover property (cap_go ##[1:3] capture_irq);
   cov_clear_a: cover property (clear_hit);
   cov_flag_clear: cover property (rd_cs && match_a_flag_r ##[1:4] clr[2]);
   cov_wrap: cover property (wrap_hit);
endmodule

// file: rtl/timer_consts.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// Byte offsets within the timer's address window
`define OFS_IRQ_EN 8'h10
`define OFS_CTRL_STATUS 8'h11
`define OFS_COUNT_HI 8'h12
`define OFS_COUNT_LO 8'h13
`define OFS_CMP_HI 8'h14
`define OFS_CMP_LO 8'h15
`define OFS_TIMER_CTRL 8'h16
`define OFS_OUT_CTRL 8'h17
`define OFS_CAP_HI 8'h18
`define OFS_CAP_LO 8'h19
// Reset values and counter maximum
`define RST_CMP 16'hffff
`define RST_CAP 16'h0000
`define RST_COUNT 16'h0000
`define RST_BYTE 8'h00
`define RST_OUT_CTRL 8'he0
`define COUNT_MAX 16'hffff
// irq_enable fields (bit 0 reads as one)
`define IE_CAPTURE 7
`define IE_MATCH_A 3
`define IE_MATCH_B 2
`define IE_WRAP 1
`define IE_ONE_MASK 8'h01
// timer_ctrl_status fields
`define CS_CAPTURE 7
`define CS_MATCH_A 3
`define CS_MATCH_B 2
`define CS_WRAP 1
`define CS_CLEAR_A 0
// timer_ctrl fields
`define TC_EDGE 7
`define TC_CKS_HI 1
`define TC_CKS_LO 0
// Output control fields (bits 7..5 read as one)
`define OC_SEL 4
`define OC_LEVEL_A 1
`define OC_LEVEL_B 0
`define OC_ONE_MASK 8'he0
// Prescaler masks for the three internal count rates (divide by 8, 32, 128)
`define PRE_MASK_8 7'h07
`define PRE_MASK_32 7'h1f
`define PRE_MASK_128 7'h7f
`endif

// file: rtl/timer_pkg.sv
// Types shared by the timer compare/capture block
package timer_pkg;
   typedef logic [15:0] count_type;
   typedef logic [7:0] byte_type;
   typedef enum logic [1:0] {SRC_DIV8, SRC_DIV32, SRC_DIV128, SRC_EXT} clk_src_type;
endpackage

// file: verification/cpu_bus_model.sv
// CPU-side byte bus model that drives the timer's register port
module cpu_bus_model
   import timer_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Byte register bus
   output logic [7:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output timer_pkg::byte_type bus_wdata,
   input wire timer_pkg::byte_type bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      bus_addr = 8'h00;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One byte write, held for one rising edge; data inverted after release
   task automatic wr8(input logic [7:0] a, input timer_pkg::byte_type d);
      @(negedge ref_clk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge ref_clk);
      bus_wr = 1'b0;
      bus_wdata = ~d;
   endtask

   // One byte read; data is registered, so it is taken a cycle later
   task automatic rd8(input logic [7:0] a, output timer_pkg::byte_type d);
      @(negedge ref_clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge ref_clk);
      bus_rd = 1'b0;
      d = bus_rdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // upper byte first
   task automatic wr16(input logic [7:0] a, input timer_pkg::count_type d);
      wr8(a, d[15:8]);
      wr8(a + 8'h01, d[7:0]);
   endtask

   task automatic rd16(input logic [7:0] a, output timer_pkg::count_type d);
      timer_pkg::byte_type hi;
      timer_pkg::byte_type lo;
      rd8(a, hi);
      rd8(a + 8'h01, lo);
      d = {hi, lo};
   endtask
endmodule

// file: verification/timer_compare_capture_irq_bench.sv
// Self-checking bench for the timer compare, capture and interrupt block
`include "timer_consts.svh"
module timer_compare_capture_irq_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;

   logic ref_clk, rst, standby, module_standby, count_clk_in, capture_in;
   logic [7:0] bus_addr;
   logic bus_rd, bus_wr;
   byte_type bus_wdata, bus_rdata, b;
   logic compare_out_a, compare_out_b, capture_irq, match_a_irq, match_b_irq, wrap_irq;
   int err_total, comparisons, cycles;
   count_type val;
   byte_type ie [4] = '{8'h81, 8'h09, 8'h05, 8'h03};

   ////////////////////////////////////////////////////////////////////////////
   // Design and bus model
   timer_compare_capture_irq i_timer_compare_capture_irq (
      .ref_clk(ref_clk), .rst(rst), .standby(standby), .module_standby(module_standby),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .count_clk_in(count_clk_in), .capture_in(capture_in),
      .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
      .capture_irq(capture_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
      .wrap_irq(wrap_irq));

   cpu_bus_model i_cpu_bus_model (
      .ref_clk(ref_clk), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the run needs well under two thousand cycles
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // external pulses held six clocks high and low
   task automatic step(input int n);
      repeat (n) begin
         count_clk_in = 1'b1;
         cyc(6);
         count_clk_in = 1'b0;
         cyc(6);
      end
   endtask

   task automatic tally_and_finish();
      $display("TB: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      standby = 1'b0;
      module_standby = 1'b0;
      count_clk_in = 1'b0;
      capture_in = 1'b0;
      cyc(10);
      rst = 1'b0;
      // Reset values and fixed bits
      check({14'h0000, compare_out_a, compare_out_b}, 16'h0000);
      i_cpu_bus_model.rd8(`OFS_IRQ_EN, b);
      check({8'h00, b}, 16'h0001);
      i_cpu_bus_model.rd8(`OFS_CTRL_STATUS, b);
      check({8'h00, b}, 16'h0000);
      i_cpu_bus_model.rd16(`OFS_CMP_HI, val);
      check(val, `RST_CMP);
      i_cpu_bus_model.wr16(`OFS_CAP_HI, 16'h5a5a);
      i_cpu_bus_model.rd16(`OFS_CAP_HI, val);
      check(val, `RST_CAP);
      i_cpu_bus_model.wr8(`OFS_IRQ_EN, 8'hff);
      i_cpu_bus_model.rd8(`OFS_IRQ_EN, b);
      check({8'h00, b}, 16'h008f);
      i_cpu_bus_model.wr8(`OFS_CTRL_STATUS, 8'hff);
      i_cpu_bus_model.rd8(`OFS_CTRL_STATUS, b);
      check({8'h00, b}, 16'h0001);
      i_cpu_bus_model.wr8(`OFS_CTRL_STATUS, 8'h00);
      // Compare A at 3, B at 5, counting external pulses from zero
      i_cpu_bus_model.wr8(`OFS_TIMER_CTRL, 8'h03);
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0000);
      i_cpu_bus_model.wr8(`OFS_OUT_CTRL, 8'he3);
      i_cpu_bus_model.wr16(`OFS_CMP_HI, 16'h0003);
      i_cpu_bus_model.wr8(`OFS_OUT_CTRL, 8'hf3);
      i_cpu_bus_model.wr16(`OFS_CMP_HI, 16'h0005);
      i_cpu_bus_model.rd16(`OFS_CMP_HI, val);
      check(val, 16'h0005);
      i_cpu_bus_model.wr8(`OFS_OUT_CTRL, 8'he3);
      i_cpu_bus_model.rd16(`OFS_CMP_HI, val);
      check(val, 16'h0003);
      step(3);
      check({14'h0000, compare_out_a, compare_out_b}, 16'h0000);
      step(1);
      check({14'h0000, compare_out_a, compare_out_b}, 16'h0002);
      step(2);
      check({14'h0000, compare_out_a, compare_out_b}, 16'h0003);
      // Wrap from all ones
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'hffff);
      step(1);
      // Capture on rising edge, then on falling edge only
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0100);
      i_cpu_bus_model.wr8(`OFS_TIMER_CTRL, 8'h83);
      capture_in = 1'b1;
      cyc(6);
      capture_in = 1'b0;
      cyc(6);
      i_cpu_bus_model.rd16(`OFS_CAP_HI, val);
      check(val, 16'h0100);
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0200);
      i_cpu_bus_model.wr8(`OFS_TIMER_CTRL, 8'h03);
      capture_in = 1'b1;
      cyc(6);
      i_cpu_bus_model.rd16(`OFS_CAP_HI, val);
      check(val, 16'h0100);
      capture_in = 1'b0;
      cyc(6);
      i_cpu_bus_model.rd16(`OFS_CAP_HI, val);
      check(val, 16'h0200);
      // Each enable alone passes only its own request
      for (int i = 0; i < 4; i++) begin
         i_cpu_bus_model.wr8(`OFS_IRQ_EN, ie[i]);
         cyc(3);
         check({12'h000, capture_irq, match_a_irq, match_b_irq, wrap_irq}, 16'h0008 >> i);
      end
      i_cpu_bus_model.wr8(`OFS_IRQ_EN, 8'h01);
      cyc(3);
      check({12'h000, capture_irq, match_a_irq, match_b_irq, wrap_irq}, 16'h0000);
      // All four flags set, then read-then-write-zero clears them
      i_cpu_bus_model.rd8(`OFS_CTRL_STATUS, b);
      check({8'h00, b}, 16'h008e);
      i_cpu_bus_model.wr8(`OFS_CTRL_STATUS, 8'h00);
      i_cpu_bus_model.rd8(`OFS_CTRL_STATUS, b);
      check({8'h00, b}, 16'h0000);
      // Match B arms, then its zero write lands on the next match B
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0005);
      step(1);
      i_cpu_bus_model.rd8(`OFS_CTRL_STATUS, b);
      check({8'h00, b}, 16'h0004);
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0005);
      fork
         i_cpu_bus_model.wr8(`OFS_CTRL_STATUS, 8'h00);
         begin
            @(negedge ref_clk);
            count_clk_in = 1'b1;
         end
      join
      cyc(5);
      count_clk_in = 1'b0;
      cyc(6);
      i_cpu_bus_model.rd8(`OFS_CTRL_STATUS, b);
      check({8'h00, b}, 16'h0004);
      // Divide by 32: 64 clocks between commit and read give two counts
      i_cpu_bus_model.wr8(`OFS_TIMER_CTRL, 8'h01);
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0000);
      cyc(63);
      i_cpu_bus_model.rd16(`OFS_COUNT_HI, val);
      check(val, 16'h0002);
      i_cpu_bus_model.wr8(`OFS_TIMER_CTRL, 8'h03);
      // Counter cleared by match A
      i_cpu_bus_model.wr8(`OFS_CTRL_STATUS, 8'h01);
      i_cpu_bus_model.wr16(`OFS_COUNT_HI, 16'h0000);
      step(4);
      i_cpu_bus_model.rd16(`OFS_COUNT_HI, val);
      check(val, 16'h0000);
      // Standby and module standby reinitialise
      standby = 1'b1;
      cyc(2);
      standby = 1'b0;
      i_cpu_bus_model.rd16(`OFS_CMP_HI, val);
      check(val, `RST_CMP);
      check({14'h0000, compare_out_a, compare_out_b}, 16'h0000);
      i_cpu_bus_model.wr8(`OFS_IRQ_EN, 8'hff);
      module_standby = 1'b1;
      cyc(2);
      module_standby = 1'b0;
      i_cpu_bus_model.rd8(`OFS_IRQ_EN, b);
      check({8'h00, b}, 16'h0001);
      i_cpu_bus_model.rd16(`OFS_CAP_HI, val);
      check(val, `RST_CAP);
      tally_and_finish();
   end
endmodule
